// ### common/sih_pkg.sv
package sih_pkg;
    // header layout
    localparam int HDR_W = 50;
    localparam int VER_POS = 0;
    localparam int VER_W = 4;
    localparam logic [3:0] VER_VALUE = 4'h0;
    localparam int NCFG_POS = 4;
    localparam int CDN_POS = 5;
    localparam int CDN_W = 11;
    localparam int OPID_POS = 16;
    localparam int OPID_W = 8;
    localparam int RSYN_POS = 24;
    localparam int NSCH_POS = 25;
    localparam int FIDX_POS = 26;
    localparam int FIDX_W = 22;
    localparam int PER_POS = 48;
    localparam int PER_W = 2;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CDN = 8'h04;
    localparam logic [7:0] ADDR_FIDX = 8'h08;
    localparam logic [7:0] ADDR_ISTAT = 8'h0C;
    localparam logic [7:0] ADDR_IMASK = 8'h10;
    // control register fields
    localparam int CTRL_NCFG = 1;
    localparam int CTRL_RSYN = 2;
    localparam int CTRL_NSCH = 3;
    localparam int CTRL_PER_LO = 4;
    localparam int CTRL_OPID_LO = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_EVENT = 1;
    localparam int IRQ_DAY = 2;
    localparam logic [2:0] IMASK_RST = 3'h0;
endpackage : sih_pkg

// ### common/sih_frm_if.sv
`timescale 1ns/1ns
`default_nettype none
// carries frame boundary events and counter state
interface sih_frm_if;
    logic boundary;  // one-cycle frame boundary
    logic midnight;  // one-cycle day wrap request
    logic load_req;  // countdown reload pending
    logic [10:0] load_val;
    logic [10:0] countdown;
    logic [21:0] frame_idx;
    logic event_hit;  // countdown just reached zero
    logic day_wrap;   // index forced to zero this boundary
    modport ctl (output boundary, output midnight, output load_req,
        output load_val, input countdown, input frame_idx,
        input event_hit, input day_wrap);
    modport cnt (input boundary, input midnight, input load_req,
        input load_val, output countdown, output frame_idx,
        output event_hit, output day_wrap);
endinterface : sih_frm_if
`default_nettype wire

// ### verilog/sih_frame_ctr.sv
`timescale 1ns/1ns
`default_nettype none
module sih_frame_ctr
    import sih_pkg::*;
(
    input wire logic pclk,     // system clock
    input wire logic presetn,  // async reset, low
    sih_frm_if.cnt frm         // boundary events and counters
);
    logic [CDN_W-1:0] cdn_r;
    logic [CDN_W-1:0] cdn_nxt;
    logic [FIDX_W-1:0] fidx_r;
    logic [FIDX_W-1:0] fidx_nxt;
    logic hit_r;
    logic wrap_r;
    logic midn_pend_r;

    // a reload wins over the running decrement
    assign cdn_nxt = frm.load_req ? frm.load_val :
        (cdn_r != '0) ? cdn_r - 1'b1 : cdn_r;
    // midnight held until the next boundary so that frame gets index 0
    assign fidx_nxt = (midn_pend_r | frm.midnight) ? '0 :
        fidx_r + 1'b1;

    // counters move only on the boundary pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdn_r <= '0;
            fidx_r <= '0;
            hit_r <= 1'b0;
            wrap_r <= 1'b0;
            midn_pend_r <= 1'b0;
        end else begin
            hit_r <= 1'b0;
            wrap_r <= 1'b0;
            if (frm.boundary) begin
                cdn_r <= cdn_nxt;
                fidx_r <= fidx_nxt;
                hit_r <= (cdn_r == 11'h001) && !frm.load_req;
                wrap_r <= midn_pend_r | frm.midnight;
                midn_pend_r <= 1'b0;
            end else if (frm.midnight) begin
                midn_pend_r <= 1'b1;
            end
        end
    end

    assign frm.countdown = cdn_r;
    assign frm.frame_idx = fidx_r;
    assign frm.event_hit = hit_r;
    assign frm.day_wrap = wrap_r;

    a_cdn_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        frm.boundary && !frm.load_req && cdn_r != '0
        |=> cdn_r == $past(cdn_r) - 11'h001)
        else $error("countdown did not step down");
    a_fidx_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !frm.boundary |=> $stable(fidx_r))
        else $error("frame index moved off a boundary");
    // a latched midnight counts as well as one in the boundary cycle
    a_fidx_wrap: assert property (
        @(posedge pclk) disable iff (!presetn)
        frm.boundary && (midn_pend_r || frm.midnight) |=> fidx_r == '0)
        else $error("frame index not zeroed at midnight");
endmodule : sih_frame_ctr
`default_nettype wire

// ### verilog/sih_header.sv
`timescale 1ns/1ns
`default_nettype none
module sih_header
    import sih_pkg::*;
(
    input wire logic pclk,           // system clock, 25 MHz
    input wire logic presetn,        // async reset, low
    input wire logic psel,           // apb select
    input wire logic penable,        // apb access phase
    input wire logic pwrite,         // apb write
    input wire logic [7:0] paddr,    // apb byte address
    input wire logic [31:0] pwdata,  // apb write data
    output logic [31:0] prdata,      // apb read data
    output logic pready,             // apb ready
    output logic pslverr,            // apb error, unmapped
    input wire logic frame_pin,      // frame tick, async
    input wire logic midnight_pin,   // 00:00 utc tick, async
    output logic [HDR_W-1:0] hdr,    // header bits 0..49
    output logic hdr_strobe,         // new header this cycle
    output logic irq                 // level interrupt
);
    sih_frm_if frm ();

    // two-flop synchronisers, then edge detect on the second stage
    logic [1:0] frm_sync_r;
    logic [1:0] mid_sync_r;
    logic frm_prev_r;
    logic mid_prev_r;
    logic boundary;
    logic midnight;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_sync_r <= 2'h0;
            mid_sync_r <= 2'h0;
            frm_prev_r <= 1'b0;
            mid_prev_r <= 1'b0;
        end else begin
            frm_sync_r <= {frm_sync_r[0], frame_pin};
            mid_sync_r <= {mid_sync_r[0], midnight_pin};
            frm_prev_r <= frm_sync_r[1];
            mid_prev_r <= mid_sync_r[1];
        end
    end

    assign boundary = frm_sync_r[1] & ~frm_prev_r;
    assign midnight = mid_sync_r[1] & ~mid_prev_r;

    // apb decode: one wait state, answer registered
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic acc;
    logic wr_ok;
    logic hit_ctrl;
    logic hit_cdn;
    logic hit_fidx;
    logic hit_istat;
    logic hit_imask;
    logic mapped;
    logic [31:0] rd_mux;

    assign acc = psel & penable & ~pready_r;
    assign wr_ok = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign hit_ctrl = (paddr == ADDR_CTRL);
    assign hit_cdn = (paddr == ADDR_CDN);
    assign hit_fidx = (paddr == ADDR_FIDX);
    assign hit_istat = (paddr == ADDR_ISTAT);
    assign hit_imask = (paddr == ADDR_IMASK);
    assign mapped = hit_ctrl | hit_cdn | hit_fidx | hit_istat | hit_imask;

    // control register and its fields
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [CDN_W-1:0] load_val_r;
    logic load_req_r;
    logic [IRQ_W-1:0] istat_r;
    logic [IRQ_W-1:0] istat_nxt;
    logic [IRQ_W-1:0] imask_r;
    logic [IRQ_W-1:0] ev;

    // only network_operator_identifier, period code and three flags are writable
    localparam logic [31:0] CTRL_WMASK = 32'h0000_FF3E;

    // flags drop by themselves in the frame the event fires
    // so a stale announcement never rides into the next frame
    assign ctrl_nxt = (wr_ok && hit_ctrl) ? (pwdata & CTRL_WMASK) :
        frm.event_hit ? (ctrl_r & ~32'h0000_000E) : ctrl_r;

    // read mux; unmapped places read as zero
    assign rd_mux = hit_ctrl ? ctrl_r :
        hit_cdn ? {21'h000000, frm.countdown} :
        hit_fidx ? {10'h000, frm.frame_idx} :
        hit_istat ? {29'h00000000, istat_r} :
        hit_imask ? {29'h00000000, imask_r} : 32'h0000_0000;

    // apb answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc & ~mapped;
            if (acc && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // answer is a one-cycle pulse, an error only rides on it
    a_ready_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready_r |=> !pready_r)
        else $error("ready held longer than one cycle");
    a_slverr_pair: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr_r |-> pready_r)
        else $error("error raised without ready");

    // event sources into sticky status; set wins over clear
    assign ev[IRQ_FRAME] = frm.boundary;
    assign ev[IRQ_EVENT] = frm.event_hit;
    assign ev[IRQ_DAY] = frm.day_wrap;
    assign istat_nxt = ((wr_ok && hit_istat) ?
        (istat_r & ~pwdata[IRQ_W-1:0]) : istat_r) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
            istat_r <= '0;
            imask_r <= IMASK_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            istat_r <= istat_nxt;
            if (wr_ok && hit_imask) begin
                imask_r <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // status bits only fall on a write; events always land
    a_istat_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr_ok && hit_istat)
        |=> (istat_r & $past(istat_r)) == $past(istat_r))
        else $error("status bit dropped without a write");
    a_bnd_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        frm.boundary |=> istat_r[IRQ_FRAME])
        else $error("frame status not set");
    a_event_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        frm.event_hit |=> istat_r[IRQ_EVENT])
        else $error("event status not set");
    a_hit_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        frm.event_hit |-> frm.countdown == '0)
        else $error("event raised with countdown not zero");

    // countdown reload waits for the next boundary; a write in the
    // boundary cycle stays pending rather than being lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_req_r <= 1'b0;
            load_val_r <= '0;
        end else if (wr_ok && hit_cdn) begin
            load_req_r <= 1'b1;
            load_val_r <= pwdata[CDN_W-1:0];
        end else if (boundary) begin
            load_req_r <= 1'b0;
        end
    end

    // a pending reload is consumed by exactly one boundary
    a_cdn_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        boundary && load_req_r |=> frm.countdown == $past(load_val_r))
        else $error("countdown reload not applied");
    a_load_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        boundary && !(wr_ok && hit_cdn) |=> !load_req_r)
        else $error("reload still pending after boundary");

    assign frm.boundary = boundary;
    assign frm.midnight = midnight;
    assign frm.load_req = load_req_r;
    assign frm.load_val = load_val_r;

    sih_frame_ctr u_ctr (
        .pclk(pclk),
        .presetn(presetn),
        .frm(frm)
    );

    // header is built one cycle after the boundary, once counters moved
    logic bnd_d_r;
    logic [HDR_W-1:0] hdr_r;
    logic [HDR_W-1:0] hdr_nxt;
    logic hdr_strobe_r;
    logic irq_r;

    always_comb begin
        hdr_nxt = '0;
        hdr_nxt[VER_POS +: VER_W] = VER_VALUE;
        hdr_nxt[NCFG_POS] = ctrl_r[CTRL_NCFG];
        hdr_nxt[CDN_POS +: CDN_W] = frm.countdown;
        hdr_nxt[OPID_POS +: OPID_W] = ctrl_r[CTRL_OPID_LO +: OPID_W];
        hdr_nxt[RSYN_POS] = ctrl_r[CTRL_RSYN];
        hdr_nxt[NSCH_POS] = ctrl_r[CTRL_NSCH];
        hdr_nxt[FIDX_POS +: FIDX_W] = frm.frame_idx;
        hdr_nxt[PER_POS +: PER_W] = ctrl_r[CTRL_PER_LO +: PER_W];
    end

    // snapshot held for the whole frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bnd_d_r <= 1'b0;
            hdr_r <= '0;
            hdr_strobe_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            bnd_d_r <= boundary;
            hdr_strobe_r <= bnd_d_r;
            irq_r <= |(istat_nxt & imask_r);
            if (bnd_d_r) begin
                hdr_r <= hdr_nxt;
            end
        end
    end

    assign hdr = hdr_r;
    assign hdr_strobe = hdr_strobe_r;
    assign irq = irq_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // header timing: fresh two cycles after a boundary, then frozen
    a_ver_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_r[VER_POS +: VER_W] == 4'h0)
        else $error("version field not zero");
    a_hdr_stable: assert property (
        @(posedge pclk) disable iff (!presetn)
        !hdr_strobe_r |-> $stable(hdr_r))
        else $error("header changed inside a frame");
    a_strobe_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_strobe_r |=> !hdr_strobe_r)
        else $error("header strobe longer than one cycle");
    a_hdr_after_bnd: assert property (
        @(posedge pclk) disable iff (!presetn)
        boundary |=> ##1 hdr_strobe_r)
        else $error("header strobe not two cycles after boundary");

    // counter fields match the counters they were copied from
    a_cdn_field: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_strobe_r |-> hdr_r[CDN_POS +: CDN_W] == frm.countdown)
        else $error("countdown field mismatch");
    a_fidx_field: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_strobe_r |-> hdr_r[FIDX_POS +: FIDX_W] == frm.frame_idx)
        else $error("frame index field mismatch");

    // software fields reflect control as it stood at the load edge
    a_opid_field: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_strobe_r |-> hdr_r[OPID_POS +: OPID_W] ==
        $past(ctrl_r[CTRL_OPID_LO +: OPID_W]))
        else $error("network operator field mismatch");
    a_per_field: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_strobe_r |-> hdr_r[PER_POS +: PER_W] ==
        $past(ctrl_r[CTRL_PER_LO +: PER_W]))
        else $error("period code field mismatch");
    a_ncfg_field: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_strobe_r |-> hdr_r[NCFG_POS] ==
        $past(ctrl_r[CTRL_NCFG]))
        else $error("next configuration flag mismatch");
    a_rsyn_field: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_strobe_r |-> hdr_r[RSYN_POS] ==
        $past(ctrl_r[CTRL_RSYN]))
        else $error("resync flag mismatch");
    a_nsch_field: assert property (
        @(posedge pclk) disable iff (!presetn)
        hdr_strobe_r |-> hdr_r[NSCH_POS] ==
        $past(ctrl_r[CTRL_NSCH]))
        else $error("next schedule flag mismatch");

    // announcements end with the event unless rewritten that cycle
    a_flags_drop: assert property (
        @(posedge pclk) disable iff (!presetn)
        frm.event_hit && !(wr_ok && hit_ctrl)
        |=> ctrl_r[CTRL_RSYN] == 1'b0 && ctrl_r[CTRL_NCFG] == 1'b0
        && ctrl_r[CTRL_NSCH] == 1'b0)
        else $error("announcement flags survived the event");

    // irq follows status and mask; a mask write shows one cycle late
    a_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        $stable(imask_r) |-> irq_r == |(istat_r & imask_r))
        else $error("interrupt level disagrees with status");
    a_apb_ready: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 psel && penable |=> pready_r)
        else $error("apb answer not after one wait state");
endmodule : sih_header
`default_nettype wire

// ### tb/sih_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
// receiver decoder: splits each new header into its fields
module sih_rx_model
    import sih_pkg::*;
(
    input wire logic pclk,             // system clock
    input wire logic [HDR_W-1:0] hdr,  // header from the framer
    input wire logic hdr_strobe,       // header is new
    output logic [31:0] fld [8]        // decoded fields
);
    // capture on the strobe only, hdr is not trusted elsewhere
    always_ff @(posedge pclk) begin
        if (hdr_strobe) begin
            fld[0] <= 32'(hdr[3:0]);
            fld[1] <= 32'(hdr[4]);
            fld[2] <= 32'(hdr[15:5]);
            fld[3] <= 32'(hdr[23:16]);
            fld[4] <= 32'(hdr[24]);
            fld[5] <= 32'(hdr[25]);
            fld[6] <= 32'(hdr[47:26]);
            fld[7] <= (32'(hdr[49:48]) + 32'h1) * 32'h2;
        end
    end
endmodule : sih_rx_model
`default_nettype wire

// ### tb/tb_signalling_infoword_header.sv
`timescale 1ns/1ns
`default_nettype none
module tb_signalling_infoword_header
    import sih_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic frame_pin = 1'b0;
    logic midnight_pin = 1'b0;
    logic [HDR_W-1:0] hdr;
    logic hdr_strobe;
    logic irq;
    logic [31:0] fld [8];
    logic [31:0] q;
    logic [31:0] r;
    logic err;
    logic [31:0] ctrl;
    logic [31:0] seed = 32'd60785;
    int errors = 0;
    int n_checks = 0;
    int cdn = 0;
    int idx = 0;
    int rld = -1;

    sih_header u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_pin(frame_pin),
        .midnight_pin(midnight_pin), .hdr(hdr),
        .hdr_strobe(hdr_strobe), .irq(irq));
    sih_rx_model u_rx (.pclk(pclk), .hdr(hdr), .hdr_strobe(hdr_strobe),
        .fld(fld));

    // 25 mhz system clock
    always #20 pclk = ~pclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // schedule period in frames from the two-bit code
    function automatic logic [31:0] exp_per(input logic [1:0] code);
        return (32'(code) + 32'h1) * 32'h2;
    endfunction : exp_per

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // master holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no cycle count assumed; only the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // one frame tick; a midnight tick goes first when asked for
    task automatic frame(input logic mid, input logic chkf);
        int n;
        logic [HDR_W-1:0] h0;
        n = 0;
        midnight_pin <= mid;
        repeat (3) @(posedge pclk);
        midnight_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        frame_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        frame_pin <= 1'b0;
        // strobe is due five edges after the pin rose
        while (hdr_strobe !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n), 32'h2);
        @(posedge pclk);
        h0 = hdr;
        if (rld >= 0) cdn = rld;
        else if (cdn > 0) cdn--;
        rld = -1;
        idx = mid ? 0 : idx + 1;
        chk(fld[0], 32'h0);
        chk(fld[2], 32'(cdn));
        chk(fld[3], 32'(ctrl[15:8]));
        chk(fld[6], 32'(idx));
        chk(fld[7], exp_per(ctrl[5:4]));
        if (chkf) begin
            chk(fld[1], 32'(ctrl[1]));
            chk(fld[4], 32'(ctrl[2]));
            chk(fld[5], 32'(ctrl[3]));
        end
        repeat (4) @(posedge pclk);
        chk(32'(hdr === h0), 32'h1);
    endtask : frame

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #(40 * 20000);
        errors++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ctrl = 32'h0;
        // reset values and an unmapped place
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(q, CTRL_RST);
        apb(1'b0, ADDR_IMASK, 32'h0);
        chk(q, 32'(IMASK_RST));
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(q, 32'h0);
        $display("test regs done");
        // every period code with random flags and network_operator_identifier
        for (int c = 0; c < 4; c++) begin
            ctrl = (rnd() & 32'h0000_FF0E) | 32'(c << 4);
            apb(1'b1, ADDR_CTRL, ctrl);
            apb(1'b0, ADDR_CTRL, 32'h0);
            chk(q, ctrl);
            frame(1'b0, 1'b1);
        end
        $display("test fields done");
        // longest announcement, then a short count to the event
        apb(1'b1, ADDR_IMASK, 32'h2);
        apb(1'b1, ADDR_CDN, 32'h0000_07FF);
        rld = 2047;
        frame(1'b0, 1'b1);
        apb(1'b0, ADDR_CDN, 32'h0);
        chk(q, 32'h0000_07FF);
        ctrl = 32'h0000_5A2E;
        apb(1'b1, ADDR_CTRL, ctrl);
        apb(1'b1, ADDR_CDN, 32'h0000_0002);
        rld = 2;
        repeat (3) frame(1'b0, 1'b1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, ADDR_ISTAT, 32'h0);
        chk(q, 32'h0000_0003);
        apb(1'b1, ADDR_ISTAT, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0);
        // announcement flags are gone once the event fired
        ctrl = ctrl & 32'hFFFF_FFF1;
        frame(1'b0, 1'b1);
        $display("test countdown done");
        // midnight forces index zero, then random day ticks
        frame(1'b1, 1'b1);
        apb(1'b0, ADDR_ISTAT, 32'h0);
        chk(q, 32'h0000_0005);
        apb(1'b0, ADDR_FIDX, 32'h0);
        chk(q, 32'(idx));
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            frame(r[0], 1'b1);
        end
        $display("test midnight done");
        end_sim();
    end
endmodule : tb_signalling_infoword_header
`default_nettype wire
